// ===== src/sync_serial_pkg.sv
// Constants, register map and carrier types of the synchronous serial port.
// Assumes a single 200 MHz system clock; nothing else.
`default_nettype none

package sync_serial_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] CTRL0_OFFSET = 12'h000;
	localparam logic [11:0] CTRL1_OFFSET = 12'h004;
	localparam logic [11:0] DATA_OFFSET = 12'h008;
	localparam logic [11:0] STATUS_OFFSET = 12'h00C;
	localparam logic [31:0] CTRL0_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;

	// ==========================================================
	// Field positions
	localparam int CTRL1_LOOPBACK_BIT = 0;
	localparam int CTRL1_ENABLE_BIT = 1;
	localparam int CTRL1_ROLE_BIT = 2;
	localparam int CTRL1_SOD_BIT = 3;
	localparam int CTRL0_SIZE_LSB = 0;
	localparam int CTRL0_CMD_BIT = 4;
	localparam int CTRL0_DIV_LSB = 8;
	localparam int STATUS_TX_EMPTY_BIT = 0;
	localparam int STATUS_TX_NOT_FULL_BIT = 1;
	localparam int STATUS_RX_NOT_EMPTY_BIT = 2;
	localparam int STATUS_RX_FULL_BIT = 3;
	localparam int STATUS_BUSY_BIT = 4;

	// ==========================================================
	// Sizes
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_PTR_W = 3;
	localparam logic [4:0] CMD_BITS = 5'h08;
	localparam logic [3:0] MIN_SIZE_CODE = 4'h3;
	localparam logic [4:0] MIN_SIZE_BITS = 5'h04;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic slave_tx_output_disable;
		logic role_select_slave;
		logic port_enable_bit;
		logic internal_loopback;
	} ctrl1_t;

	typedef struct packed {
		logic [7:0] clk_div;
		logic cmd_frame;
		logic [3:0] size_code;
	} ctrl0_t;

	typedef enum {ENG_IDLE, ENG_SHIFT, ENG_TAIL, ENG_GAP} eng_state_t;
endpackage

`default_nettype wire

// ===== src/serial_word_fifo.sv
// Word FIFO used for the transmit and receive queues.
// Assumes the caller never pushes when full nor pops when empty.
`default_nettype none

module serial_word_fifo (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic push_in,
	input wire logic [sync_serial_pkg::WORD_W-1:0] push_data_in,
	input wire logic pop_in,
	output logic [sync_serial_pkg::WORD_W-1:0] head_out,
	output logic empty_out,
	output logic full_out
);
	// ==========================================================
	// Storage and pointers
	logic [sync_serial_pkg::WORD_W-1:0] mem [sync_serial_pkg::FIFO_DEPTH];
	logic [sync_serial_pkg::FIFO_PTR_W:0] wr_ptr;
	logic [sync_serial_pkg::FIFO_PTR_W:0] rd_ptr;
	logic [sync_serial_pkg::FIFO_PTR_W:0] next_wr_ptr;
	logic [sync_serial_pkg::FIFO_PTR_W:0] next_rd_ptr;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push_in) begin
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop_in) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage has no reset; contents before the first push are never read
	always_ff @(posedge core_clk_in) begin
		if (push_in) begin
			mem[wr_ptr[sync_serial_pkg::FIFO_PTR_W-1:0]] <= push_data_in;
		end
	end

	assign head_out = mem[rd_ptr[sync_serial_pkg::FIFO_PTR_W-1:0]];
	assign empty_out = (wr_ptr == rd_ptr);
	assign full_out = (wr_ptr[sync_serial_pkg::FIFO_PTR_W-1:0] ==
		rd_ptr[sync_serial_pkg::FIFO_PTR_W-1:0]) &&
		(wr_ptr[sync_serial_pkg::FIFO_PTR_W] != rd_ptr[sync_serial_pkg::FIFO_PTR_W]);
endmodule

`default_nettype wire

// ===== src/sync_serial_port.sv
// Synchronous serial port: control registers, data port, FIFOs, shift engine.
// Assumes an AXI4-Lite master on the system clock and external serial pins.
//
// Summary of operation
// RULE1: Slave role with output disable set leaves the transmit pin undriven.
// RULE2: Output disable only matters in slave role; master ignores it.
// RULE3: Role bit 2 selects master at 0, slave at 1; resets to master.
// RULE4: Software changes role only while the port is disabled.
// RULE5: Enable bit 1 starts serial operation at 1, halts it at 0.
// RULE6: Software disables the port before rewriting control registers.
// RULE7: Loopback bit 0 feeds transmit shifter output into receive shifter.
// RULE8: Data port carries 16 bits in 15:0; upper bits reserved.
// RULE9: Reading the data port returns and removes the receive FIFO head.
// RULE10: Writing the data port stores the value into the transmit FIFO.
// RULE11: Each received word is written into the receive FIFO.
// RULE12: Transmit logic loads one FIFO word into the shifter and shifts it out.
// RULE13: Short words are right-justified; unused upper transmit bits are dropped.
// RULE14: Short received words are stored right-justified.
// RULE15: Command frame format sends only the low byte of each word.
// RULE16: Command frame format receives words of the programmed data size.
// RULE17: Disabling the port never flushes either FIFO.
// RULE18: Reserved bits read undefined (zero here); software preserves them.
// RULE19: In loopback the external receive pin is ignored.
// RULE20: While disabled no frame starts; clock and transmit pin sit idle.
//
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none

module sync_serial_port (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic serial_clk_out,
	input wire logic serial_clk_in,
	output logic frame_sel_n_out,
	input wire logic frame_sel_n_in,
	output logic serial_tx_pin_out,
	output logic serial_tx_pin_oe_n_out,
	input wire logic serial_rx_in
);
	// ==========================================================
	// Register file and AXI4-Lite slave
	sync_serial_pkg::ctrl0_t ctrl0, next_ctrl0;
	sync_serial_pkg::ctrl1_t ctrl1, next_ctrl1;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [11:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic awready, next_awready;
	logic wready, next_wready;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic arready, next_arready;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic tx_push;
	logic rx_pop;
	logic [15:0] tx_head, rx_head;
	logic tx_empty, tx_full, rx_empty, rx_full;
	logic busy;
	sync_serial_pkg::eng_state_t state, next_state;

	always_comb begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		tx_push = 1'b0;
		rx_pop = 1'b0;
		if (s_axi_awvalid_in && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb = s_axi_wstrb_in;
		end
		if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = sync_serial_pkg::RESP_OKAY;
			unique case ({aw_addr[11:2], 2'b00})
				sync_serial_pkg::CTRL0_OFFSET: begin
					if (w_strb[0]) begin
						next_ctrl0.cmd_frame = w_data[sync_serial_pkg::CTRL0_CMD_BIT];
						next_ctrl0.size_code = w_data[sync_serial_pkg::CTRL0_SIZE_LSB+:4];
					end
					if (w_strb[1]) begin
						next_ctrl0.clk_div = w_data[sync_serial_pkg::CTRL0_DIV_LSB+:8];
					end
				end
				sync_serial_pkg::CTRL1_OFFSET: begin
					if (w_strb[0]) begin
						next_ctrl1.slave_tx_output_disable = w_data[sync_serial_pkg::CTRL1_SOD_BIT];
						next_ctrl1.role_select_slave = w_data[sync_serial_pkg::CTRL1_ROLE_BIT]; // see RULE3
						next_ctrl1.port_enable_bit = w_data[sync_serial_pkg::CTRL1_ENABLE_BIT];
						next_ctrl1.internal_loopback = w_data[sync_serial_pkg::CTRL1_LOOPBACK_BIT];
					end
				end
				sync_serial_pkg::DATA_OFFSET: begin
					// A write to a full queue is dropped rather than overwriting the oldest word
					tx_push = !tx_full; // see RULE10
				end
				sync_serial_pkg::STATUS_OFFSET: begin
				end
				default: begin
					next_bresp = sync_serial_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && arready) begin
			next_rvalid = 1'b1;
			next_rresp = sync_serial_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000; // see RULE18
			unique case ({s_axi_araddr_in[11:2], 2'b00})
				sync_serial_pkg::CTRL0_OFFSET: begin
					next_rdata[sync_serial_pkg::CTRL0_DIV_LSB+:8] = ctrl0.clk_div;
					next_rdata[sync_serial_pkg::CTRL0_CMD_BIT] = ctrl0.cmd_frame;
					next_rdata[sync_serial_pkg::CTRL0_SIZE_LSB+:4] = ctrl0.size_code;
				end
				sync_serial_pkg::CTRL1_OFFSET: begin
					next_rdata[3:0] = ctrl1;
				end
				sync_serial_pkg::DATA_OFFSET: begin
					// Empty queue reads as zero and pops nothing
					next_rdata[15:0] = rx_empty ? 16'h0000 : rx_head; // see RULE8
					rx_pop = !rx_empty; // see RULE9
				end
				sync_serial_pkg::STATUS_OFFSET: begin
					next_rdata[sync_serial_pkg::STATUS_TX_EMPTY_BIT] = tx_empty;
					next_rdata[sync_serial_pkg::STATUS_TX_NOT_FULL_BIT] = !tx_full;
					next_rdata[sync_serial_pkg::STATUS_RX_NOT_EMPTY_BIT] = !rx_empty;
					next_rdata[sync_serial_pkg::STATUS_RX_FULL_BIT] = rx_full;
					next_rdata[sync_serial_pkg::STATUS_BUSY_BIT] = busy;
				end
				default: begin
					next_rresp = sync_serial_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl0 <= sync_serial_pkg::CTRL0_RESET[12:0];
			ctrl1 <= sync_serial_pkg::CTRL1_RESET[3:0];
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else begin
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign s_axi_awready_out = awready;
	assign s_axi_wready_out = wready;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_arready_out = arready;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;

	// ==========================================================
	// Queues, never flushed by the enable bit
	logic tx_pop, rx_push;
	logic [15:0] rx_push_data;

	serial_word_fifo tx_fifo ( // see RULE17
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.push_in(tx_push),
		.push_data_in(w_data[15:0]),
		.pop_in(tx_pop),
		.head_out(tx_head),
		.empty_out(tx_empty),
		.full_out(tx_full)
	);

	serial_word_fifo rx_fifo (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.push_in(rx_push),
		.push_data_in(rx_push_data),
		.pop_in(rx_pop),
		.head_out(rx_head),
		.empty_out(rx_empty),
		.full_out(rx_full)
	);

	// ==========================================================
	// Pin synchronisers; stage one feeds only stage two
	logic [2:0] sclk_sync, fsel_sync;
	logic [1:0] rx_sync;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_sync <= 3'h0;
			fsel_sync <= 3'h7;
			rx_sync <= 2'h0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], serial_clk_in};
			fsel_sync <= {fsel_sync[1:0], frame_sel_n_in};
			rx_sync <= {rx_sync[0], serial_rx_in};
		end
	end

	// ==========================================================
	// Shift engine
	logic [15:0] tx_sh, next_tx_sh;
	logic [15:0] rx_sh, next_rx_sh;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [7:0] half_cnt, next_half_cnt;
	logic sclk, next_sclk;
	logic fsel_n, next_fsel_n;
	logic tx_out, next_tx_out;
	logic tx_oe_n, next_tx_oe_n;
	logic [4:0] size_bits, total_bits;
	logic [15:0] size_mask;
	logic slave, tick, rise_ev, fall_ev, rx_bit, s_rise, s_fall, s_start, s_end;

	always_comb begin
		slave = ctrl1.role_select_slave;
		size_bits = (ctrl0.size_code < sync_serial_pkg::MIN_SIZE_CODE) ?
			sync_serial_pkg::MIN_SIZE_BITS : {1'b0, ctrl0.size_code} + 5'h01;
		size_mask = 16'hFFFF >> (5'h10 - size_bits); // see RULE14
		total_bits = ctrl0.cmd_frame ? sync_serial_pkg::CMD_BITS + size_bits : size_bits; // see RULE16
		s_rise = sclk_sync[1] && !sclk_sync[2];
		s_fall = !sclk_sync[1] && sclk_sync[2];
		s_start = !fsel_sync[1] && fsel_sync[2];
		s_end = fsel_sync[1];
		tick = (half_cnt == 8'h00);
		rise_ev = slave ? s_rise : (tick && !sclk);
		fall_ev = slave ? s_fall : (tick && sclk);
		// Loopback masks the pin so a floating line cannot corrupt the self test
		rx_bit = ctrl1.internal_loopback ? tx_sh[15] : rx_sync[1]; // see RULE7, RULE19
		next_state = state;
		next_tx_sh = tx_sh;
		next_rx_sh = rx_sh;
		next_bit_cnt = bit_cnt;
		next_half_cnt = tick ? ctrl0.clk_div : half_cnt - 8'h01;
		next_sclk = sclk;
		next_fsel_n = fsel_n;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_push_data = 16'h0000;
		unique case (state)
			sync_serial_pkg::ENG_IDLE: begin
				next_sclk = 1'b0;
				next_fsel_n = 1'b1;
				if (ctrl1.port_enable_bit && (slave ? s_start : !tx_empty)) begin // see RULE5
					tx_pop = !tx_empty; // see RULE12
					if (tx_empty) begin
						next_tx_sh = 16'h0000;
					end else if (ctrl0.cmd_frame) begin
						next_tx_sh = {tx_head[7:0], 8'h00}; // see RULE15
					end else begin
						next_tx_sh = tx_head << (5'h10 - size_bits); // see RULE13
					end
					next_rx_sh = 16'h0000;
					next_bit_cnt = 5'h00;
					next_half_cnt = ctrl0.clk_div;
					next_fsel_n = slave;
					next_state = sync_serial_pkg::ENG_SHIFT;
				end
			end
			sync_serial_pkg::ENG_SHIFT: begin
				if (!slave && tick) begin
					next_sclk = !sclk;
				end
				if (rise_ev) begin
					next_rx_sh = {rx_sh[14:0], rx_bit};
					next_bit_cnt = bit_cnt + 5'h01;
					if (next_bit_cnt == total_bits) begin
						// Overrun drops the new word; the queue keeps its older ones
						rx_push = !rx_full; // see RULE11
						rx_push_data = next_rx_sh & size_mask; // see RULE14
						next_state = slave ? sync_serial_pkg::ENG_GAP : sync_serial_pkg::ENG_TAIL;
					end
				end else if (fall_ev) begin
					next_tx_sh = {tx_sh[14:0], 1'b0};
				end
				if (slave && s_end) begin
					next_state = sync_serial_pkg::ENG_IDLE;
				end
			end
			sync_serial_pkg::ENG_TAIL: begin
				if (tick) begin
					next_sclk = 1'b0;
					next_state = sync_serial_pkg::ENG_GAP;
				end
			end
			sync_serial_pkg::ENG_GAP: begin
				if (slave ? s_end : tick) begin
					next_fsel_n = 1'b1;
					next_state = sync_serial_pkg::ENG_IDLE;
				end
			end
		endcase
		if (!ctrl1.port_enable_bit) begin
			// Halting mid frame abandons the word in the shifter
			next_state = sync_serial_pkg::ENG_IDLE; // see RULE20
			next_sclk = 1'b0;
			next_fsel_n = 1'b1;
		end
		next_tx_out = (next_state == sync_serial_pkg::ENG_SHIFT ||
			next_state == sync_serial_pkg::ENG_TAIL) ? next_tx_sh[15] : 1'b0; // see RULE20
		next_tx_oe_n = slave && (ctrl1.slave_tx_output_disable || !ctrl1.port_enable_bit); // see RULE1, RULE2
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= sync_serial_pkg::ENG_IDLE;
			tx_sh <= 16'h0000;
			rx_sh <= 16'h0000;
			bit_cnt <= 5'h00;
			half_cnt <= 8'h00;
			sclk <= 1'b0;
			fsel_n <= 1'b1;
			tx_out <= 1'b0;
			tx_oe_n <= 1'b0;
		end else begin
			state <= next_state;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			bit_cnt <= next_bit_cnt;
			half_cnt <= next_half_cnt;
			sclk <= next_sclk;
			fsel_n <= next_fsel_n;
			tx_out <= next_tx_out;
			tx_oe_n <= next_tx_oe_n;
		end
	end

	assign busy = (state != sync_serial_pkg::ENG_IDLE) || !tx_empty;
	assign serial_clk_out = sclk;
	assign frame_sel_n_out = fsel_n;
	assign serial_tx_pin_out = tx_out;
	assign serial_tx_pin_oe_n_out = tx_oe_n;
endmodule

`default_nettype wire

// ===== tb/sync_serial_port_props.sv
// Checker of the serial port: bus answers, pin levels and link timing.
// Assumes it is bound to the port's top module and sees only its ports.
`default_nettype none

module sync_serial_port_props (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic serial_clk_out,
	input wire logic frame_sel_n_out,
	input wire logic serial_tx_pin_out,
	input wire logic serial_tx_pin_oe_n_out
);
	// ====
	// Shadow of the control bits; trusted only while no write is in flight
	logic [11:0] addr_q;
	logic [3:0] data_q;
	logic [3:0] ctl;
	logic bv_q;
	logic idle;
	assign idle = s_axi_awready_out && !s_axi_bvalid_out;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_q <= 12'h000;
			data_q <= 4'h0;
			ctl <= 4'h0;
			bv_q <= 1'b0;
		end else begin
			bv_q <= s_axi_bvalid_out;
			if (s_axi_awvalid_in && s_axi_awready_out) addr_q <= s_axi_awaddr_in;
			if (s_axi_wvalid_in && s_axi_wready_out) data_q <= s_axi_wdata_in[3:0];
			if (s_axi_bvalid_out && !bv_q && addr_q[11:2] == 10'h001) ctl <= data_q;
		end
	end

	// ====
	// Properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sod_float_a: assert property (idle && ctl[2] && ctl[3] |-> serial_tx_pin_oe_n_out)
		else $error("tx pin driven with output disable set");
	master_drive_a: assert property (idle && !ctl[2] |-> !serial_tx_pin_oe_n_out)
		else $error("tx pin released in master role");
	idle_pins_a: assert property (idle && !ctl[1] |->
		!serial_clk_out && frame_sel_n_out && !serial_tx_pin_out)
		else $error("link pins active while disabled");
	clk_in_frame_a: assert property ($rose(serial_clk_out) |-> !frame_sel_n_out)
		else $error("serial clock outside frame");
	tx_hold_a: assert property (serial_clk_out && $past(serial_clk_out)
		|-> $stable(serial_tx_pin_out))
		else $error("tx changed while clock high");
	write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("write response late");
	read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out)
		else $error("read data late");
	read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read data dropped early");
endmodule

`default_nettype wire

// ===== tb/serial_link_partner.sv
// Far end of the serial link: a mode 0 slave, or a master run by task.
// Assumes the bench gives it the transmit line with a pull-up applied.
`default_nettype none

module serial_link_partner (
	input wire logic sclk_in,
	input wire logic fsel_n_in,
	input wire logic tx_in,
	input wire logic [15:0] reply_in,
	input wire logic [4:0] bits_in,
	output logic rx_out,
	output logic m_sclk_out,
	output logic m_fsel_n_out,
	output logic [15:0] got_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int idx;
	initial begin
		rx_out = 1'h0;
		m_sclk_out = 1'h0;
		m_fsel_n_out = 1'h1;
		got_out = 16'h0000;
		idx = 0;
	end

	// ====
	// Slave: answer MSB first, change after each falling clock edge
	always @(negedge fsel_n_in) begin
		idx = int'(bits_in) - 1;
		got_out = 16'h0000;
		rx_out = reply_in[idx];
	end
	always @(posedge sclk_in) got_out = {got_out[14:0], tx_in};
	always @(negedge sclk_in) begin
		if (!fsel_n_in && idx > 0) begin
			idx--;
			rx_out = reply_in[idx];
		end
	end
	// No pull on the line: a stale bit must not pass for data
	always @(posedge fsel_n_in) rx_out = ~rx_out;

	// ====
	// Master: link clock of 125 ns runs only inside the frame
	task automatic master_frame(input logic [15:0] w, input int n);
		m_fsel_n_out = 1'h0;
		got_out = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			rx_out = w[i];
			#62.5;
			m_sclk_out = 1'h1;
			got_out = {got_out[14:0], tx_in};
			#62.5;
			m_sclk_out = 1'h0;
		end
		#62.5;
		m_fsel_n_out = 1'h1;
		rx_out = ~rx_out;
	endtask
endmodule

`default_nettype wire

// ===== tb/tb_sync_serial_port.sv
// Self-checking bench of the serial port: registers, frames, roles, loopback.
// Assumes the package, design, checker and link partner are compiled first.
`default_nettype none

module tb_sync_serial_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] ctl0_a = sync_serial_pkg::CTRL0_OFFSET;
	localparam logic [11:0] ctl1_a = sync_serial_pkg::CTRL1_OFFSET;
	localparam logic [11:0] data_a = sync_serial_pkg::DATA_OFFSET;
	logic clk, rst, awv, wv, bre, arv, rre;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdv, seed;
	logic [1:0] rsp;
	logic [15:0] reply, w [2], rp [2];
	logic [4:0] nbits;
	logic [3:0] code;
	wire logic awr, wr, bv, arr, rv, sclk, fsn, tx, oen, m_sclk, m_fsn, rx, txw;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd;
	wire logic [15:0] got;
	int bad_count, num_checks, cyc, n;
	// Shared transmit line has a pull-up when no one drives it
	assign txw = oen ? 1'h1 : tx;

	sync_serial_port DUT (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
		.s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rre), .serial_clk_out(sclk), .serial_clk_in(m_sclk),
		.frame_sel_n_out(fsn), .frame_sel_n_in(m_fsn), .serial_tx_pin_out(tx),
		.serial_tx_pin_oe_n_out(oen), .serial_rx_in(rx));
	serial_link_partner LINK (.sclk_in(sclk), .fsel_n_in(fsn), .tx_in(txw), .reply_in(reply),
		.bits_in(nbits), .rx_out(rx), .m_sclk_out(m_sclk), .m_fsel_n_out(m_fsn), .got_out(got));

	// ====
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [15:0] exp_tx(input logic [15:0] v, input int sz, input logic cmd);
		return cmd ? 16'({8'h00, v[7:0]} << sz) : v & (16'hFFFF >> (16 - sz));
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		while (1) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wr) wv <= 1'h0;
			if (!awv && !wv && bv) break;
		end
		rsp = br;
		bre <= 1'h0;
	endtask
	task automatic rd_reg(input logic [11:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		// Ready follows valid by a cycle, so the slave must hold its answer
		while (1) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'h0;
			else if (!arv && rv && rre) break;
			else if (!arv && rv) rre <= 1'h1;
		end
		rdv = rd;
		rsp = rr;
		rre <= 1'h0;
	endtask

	// ====
	// Clock, watchdog and sequence
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		rst = 1'h1;
		{awv, wv, bre, arv, rre} = 5'h00;
		awa = 12'h000;
		ara = 12'h000;
		wd = 32'h0;
		reply = 16'h0000;
		nbits = 5'h10;
		seed = 32'h89F0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd_reg(ctl1_a);
		chk("ctrl1 reset", 32'h0, rdv);
		chk("tx enable", 32'h0, oen);
		chk("frame select", 32'h1, fsn);
		rd_reg(data_a);
		chk("empty data", 32'h0, rdv);
		rd_reg(12'h040);
		chk("unmapped", 32'(sync_serial_pkg::RESP_SLVERR), rsp);
		wr_reg(ctl1_a, 32'h0000_000D);
		chk("write resp", 32'(sync_serial_pkg::RESP_OKAY), rsp);
		rd_reg(ctl1_a);
		chk("ctrl1 fields", 32'h0000_000D, rdv);
		wr_reg(ctl1_a, 32'h0);
		// Full size, random size in loopback, smallest size, command frames
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			code = (i == 1) ? 4'h4 + 4'(seed[7:0] % 11) : (i == 2) ? 4'h3 : (i == 3) ? 4'h7 : 4'hF;
			n = int'(code) + 1;
			wr_reg(ctl0_a, {16'h0000, 8'h0B, 3'h0, 1'(i == 3), code});
			for (int j = 0; j < 2; j++) begin
				seed = lfsr(seed);
				w[j] = seed[15:0];
				rp[j] = (i == 1) ? ~seed[15:0] : seed[31:16];
				wr_reg(data_a, {16'h0000, w[j]});
			end
			repeat (2) @(negedge clk);
			chk("held while off", 32'h1, fsn);
			rd_reg(sync_serial_pkg::STATUS_OFFSET);
			chk("preload status", 32'h12, rdv);
			reply = rp[0];
			nbits = 5'(n + ((i == 3) ? 8 : 0));
			wr_reg(ctl1_a, (i == 1) ? 32'h3 : 32'h2);
			for (int j = 0; j < 2; j++) begin
				@(posedge fsn);
				reply = rp[1];
				if (i != 1) chk("link word", exp_tx(w[j], n, i == 3), got);
			end
			wr_reg(ctl1_a, 32'h0);
			for (int j = 0; j < 2; j++) begin
				rd_reg(data_a);
				chk("rx word", exp_tx((i == 1) ? w[j] : rp[j], n, 1'h0), rdv);
			end
		end
		wr_reg(ctl0_a, 32'h0000_000F);
		wr_reg(ctl1_a, 32'h4);
		seed = lfsr(seed);
		wr_reg(data_a, {16'h0000, seed[15:0]});
		wr_reg(ctl1_a, 32'h6);
		LINK.master_frame(seed[31:16], 16);
		chk("slave tx", {16'h0000, seed[15:0]}, got);
		wr_reg(ctl1_a, 32'h4);
		rd_reg(data_a);
		chk("slave rx", {16'h0000, seed[31:16]}, rdv);
		wr_reg(ctl1_a, 32'hC);
		wr_reg(ctl1_a, 32'hE);
		repeat (2) @(negedge clk);
		chk("slave released", 32'h1, oen);
		wr_reg(ctl1_a, 32'hC);
		wr_reg(ctl1_a, 32'h8);
		wr_reg(ctl1_a, 32'hA);
		repeat (2) @(negedge clk);
		chk("master drives", 32'h0, oen);
		wr_reg(ctl1_a, 32'h0);
		close_out();
	end
endmodule

bind sync_serial_port sync_serial_port_props PROPS (.core_clk_in, .rst_in, .s_axi_awaddr_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .serial_clk_out, .frame_sel_n_out,
	.serial_tx_pin_out, .serial_tx_pin_oe_n_out);

`default_nettype wire
